// File: dee_pkg.sv
package dee_pkg;

  // ----------------------------------------------------------------
  // register offsets on the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_KEY = 3'h1;
  localparam logic [2:0] OFF_ADR_LO = 3'h2;
  localparam logic [2:0] OFF_ADR_HI = 3'h3;
  localparam logic [2:0] OFF_DATA = 3'h4;
  localparam logic [2:0] OFF_FLAG = 3'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_RD_GO = 0;
  localparam int BIT_WR_GO = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_ABORT = 3;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_PROG_SEL = 7;
  localparam int BIT_DONE_FLAG = 4;

  // ----------------------------------------------------------------
  // values, sizes and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int ADDR_W = 10;
  localparam int ADDR_LO_W = 8;
  localparam int DATA_W = 8;
  localparam int WRITE_CYCLES_DEF = 400;
  localparam int PWRT_CYCLES_DEF = 64;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_FINISH = 2'h3
  } dee_state_t;

  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_ARMED = 2'h3
  } dee_key_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } dee_req_t;

  typedef struct packed {
    logic prog_sel;
    logic cfg_sel;
    logic row_erase;
    logic permit;
    logic wr_go;
    logic rd_go;
  } dee_ctrl_t;

endpackage

// File: dee_mem.sv
`timescale 1ns/1ps
module dee_mem
  import dee_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // no reset: the array models nonvolatile cells
  logic [DW-1:0] cells [0:(1<<AW)-1];

  if (AW < 1 || DW < 1) begin : g_bad_geometry
    $error("dee_mem: bad geometry");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    if (re) begin
      rdata_q <= cells[raddr];
    end
  end

endmodule // dee_mem

// File: dee_ctrl.sv
`timescale 1ns/1ps
module dee_ctrl
  import dee_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
  parameter int PWRT_CYCLES = PWRT_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic POR_B,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic WRITE_BUSY,
  output logic WRITE_DONE_FLAG,
  output logic FLASH_OP_DONE,
  output logic FLASH_ROW_ERASE
);

  // ----------------------------------------------------------------
  // sizes and checks
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam int PW_W = $clog2(PWRT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [PW_W-1:0] PW_LAST = PW_W'(PWRT_CYCLES);

  if (WRITE_CYCLES < 1 || PWRT_CYCLES < 1) begin : g_bad_counts
    $error("dee_ctrl: counts must be at least one");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dee_req_t req;
  dee_ctrl_t ctrl_q, ctrl_d;
  dee_state_t state_q, state_d;
  dee_key_t key_q, key_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PW_W-1:0] pw_q, pw_d;
  logic pwrt_done_q, pwrt_done_d;
  logic [ADDR_W-1:0] adr_q, adr_d;
  logic [7:0] data_q, data_d;
  logic done_q, done_d;
  logic abort_q, abort_d;
  logic [7:0] rdata_q, rdata_d;
  logic busy_q, busy_d;
  logic fdone_q, fdone_d;
  logic ferase_q, ferase_d;
  logic [7:0] mem_rdata;
  logic mem_we, mem_re;
  logic wr_ctrl, go_req, go_ok, go_bad, rd_ok;
  logic data_target;

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // ----------------------------------------------------------------
  // start decisions
  // ----------------------------------------------------------------
  assign wr_ctrl = req.wr && req.addr == OFF_CTRL && state_q == ST_IDLE;
  assign go_req = wr_ctrl && req.wdata[BIT_WR_GO];
  // permit gate
  // permit must already be set: setting both in one write is refused
  assign go_ok = go_req && ctrl_q.permit && key_q == KEY_ARMED && pwrt_done_q;
  assign go_bad = go_req && pwrt_done_q && !go_ok;
  // read refused
  // a read taken with an accepted go would change the data register mid-write
  assign rd_ok = wr_ctrl && req.wdata[BIT_RD_GO] && !req.wdata[BIT_PROG_SEL] && !req.wdata[BIT_CFG_SEL] && !go_ok;
  assign data_target = !ctrl_q.cfg_sel && !ctrl_q.prog_sel;
  // commit at the end of the timed cycle
  assign mem_we = state_q == ST_FINISH && data_target;
  assign mem_re = rd_ok;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    key_d = key_q;
    cnt_d = cnt_q;
    pw_d = pw_q;
    pwrt_done_d = pwrt_done_q;
    adr_d = adr_q;
    data_d = data_q;
    done_d = done_q;
    abort_d = abort_q;
    rdata_d = BYTE_ZERO;
    fdone_d = 1'b0;
    ferase_d = ferase_q;
    if (!pwrt_done_q) begin
      pw_d = pw_q + PW_W'(1);
      pwrt_done_d = pw_q + PW_W'(1) == PW_LAST;
    end
    ctrl_d.rd_go = rd_ok;
    if (req.wr) begin
      if (req.addr == OFF_KEY && req.wdata == KEY_FIRST) begin
        key_d = KEY_HALF;
      end else if (req.addr == OFF_KEY && req.wdata == KEY_SECOND && key_q == KEY_HALF) begin
        key_d = KEY_ARMED;
      end else begin
        key_d = KEY_NONE;
      end
    end
    if (wr_ctrl) begin
      ctrl_d.prog_sel = req.wdata[BIT_PROG_SEL];
      ctrl_d.cfg_sel = req.wdata[BIT_CFG_SEL];
      ctrl_d.row_erase = req.wdata[BIT_ROW_ERASE];
      ctrl_d.permit = req.wdata[BIT_PERMIT];
    end
    if (req.wr && state_q == ST_IDLE && req.addr == OFF_ADR_LO) begin
      adr_d[ADDR_LO_W-1:0] = req.wdata;
    end
    if (req.wr && state_q == ST_IDLE && req.addr == OFF_ADR_HI) begin
      adr_d[ADDR_W-1:ADDR_LO_W] = req.wdata[ADDR_W-ADDR_LO_W-1:0];
    end
    // data holds until read or write
    if (req.wr && state_q == ST_IDLE && req.addr == OFF_DATA) begin
      data_d = req.wdata;
    end
    if (ctrl_q.rd_go) begin
      data_d = mem_rdata;
    end
    if (req.wr && req.addr == OFF_FLAG && !req.wdata[BIT_DONE_FLAG]) begin
      done_d = 1'b0;
    end
    if (go_bad) begin
      abort_d = 1'b1;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (go_ok) begin
          ctrl_d.wr_go = 1'b1;
          abort_d = 1'b1;
          cnt_d = CNT_LOAD;
          state_d = ST_WRITE;
          ferase_d = !req.wdata[BIT_CFG_SEL] && req.wdata[BIT_PROG_SEL] && req.wdata[BIT_ROW_ERASE];
        end
      end
      ST_WRITE: begin
        if (cnt_q == '0) begin
          state_d = ST_FINISH;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_FINISH: begin
        ctrl_d.wr_go = 1'b0;
        abort_d = 1'b0;
        done_d = 1'b1;
        fdone_d = !data_target;
        if (ferase_q) begin
          ctrl_d.row_erase = 1'b0;
        end
        ferase_d = 1'b0;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = state_d != ST_IDLE;
    if (req.rd) begin
      unique case (req.addr)
        // select bits never cleared by abort
        OFF_CTRL: rdata_d = {ctrl_q.prog_sel, ctrl_q.cfg_sel, 1'b0, ctrl_q.row_erase, abort_q,
                             ctrl_q.permit, ctrl_q.wr_go, ctrl_q.rd_go};
        OFF_KEY: rdata_d = BYTE_ZERO;
        OFF_ADR_LO: rdata_d = adr_q[ADDR_LO_W-1:0];
        OFF_ADR_HI: rdata_d = {{(16-ADDR_W){1'b0}}, adr_q[ADDR_W-1:ADDR_LO_W]};
        OFF_DATA: rdata_d = ctrl_q.rd_go ? mem_rdata : data_q;
        OFF_FLAG: rdata_d = 8'(done_q) << BIT_DONE_FLAG;
        default: rdata_d = BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= '0;
      state_q <= ST_IDLE;
      key_q <= KEY_NONE;
      cnt_q <= '0;
      pw_q <= '0;
      pwrt_done_q <= 1'b0;
      adr_q <= '0;
      data_q <= BYTE_ZERO;
      done_q <= 1'b0;
      rdata_q <= BYTE_ZERO;
      busy_q <= 1'b0;
      fdone_q <= 1'b0;
      ferase_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      key_q <= key_d;
      cnt_q <= cnt_d;
      pw_q <= pw_d;
      pwrt_done_q <= pwrt_done_d;
      adr_q <= adr_d;
      data_q <= data_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      busy_q <= busy_d;
      fdone_q <= fdone_d;
      ferase_q <= ferase_d;
    end
  end

  // survives a reset that cuts a write short
  // only power-on or the finish of a write clears it, so a reset mid-cycle leaves it set
  always_ff @(posedge MCLK or negedge POR_B) begin
    if (!POR_B) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  dee_mem #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_mem (
    .clk(MCLK),
    .we(mem_we),
    .waddr(adr_q),
    .wdata(data_q),
    .re(mem_re),
    .raddr(adr_q),
    .rdata_q(mem_rdata)
  );

  assign REG_RDATA = rdata_q;
  assign WRITE_BUSY = busy_q;
  assign WRITE_DONE_FLAG = done_q;
  assign FLASH_OP_DONE = fdone_q;
  assign FLASH_ROW_ERASE = ferase_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  // checker helper: edges spent in the timed state, counted apart from cnt_q
  logic [CNT_W-1:0] wlen_q, wlen_d;

  always_comb begin
    wlen_d = state_q == ST_WRITE ? wlen_q + CNT_W'(1) : '0;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      wlen_q <= '0;
    end else begin
      wlen_q <= wlen_d;
    end
  end

  sequence s_go_start;
    $rose(ctrl_q.wr_go);
  endsequence

  sequence s_go_end;
    $fell(ctrl_q.wr_go);
  endsequence

  rd_refused_a: assert property (ctrl_q.rd_go |-> !ctrl_q.prog_sel && !ctrl_q.cfg_sel)
    else $error("read go accepted with program or config selected");
  rd_pulse_a: assert property (ctrl_q.rd_go |=> !ctrl_q.rd_go)
    else $error("read go did not self clear");
  go_permit_a: assert property (s_go_start |-> $past(ctrl_q.permit) && $past(key_q) == KEY_ARMED)
    else $error("write started without permit or unlock");
  go_abort_a: assert property (s_go_start |-> abort_q)
    else $error("abort flag not set at write start");
  timer_end_a: assert property (state_q == ST_FINISH |-> wlen_q == CNT_W'(WRITE_CYCLES))
    else $error("write cycle ended before timer expiry");
  done_set_a: assert property (s_go_end |-> done_q && !abort_q)
    else $error("completion did not set done or clear abort");
  busy_hold_a: assert property (ctrl_q.wr_go && $past(ctrl_q.wr_go) |-> $stable(ctrl_q.prog_sel)
    && $stable(ctrl_q.cfg_sel) && $stable(adr_q) && $stable(data_q))
    else $error("registers changed during a write");
  key_zero_a: assert property (req.rd && req.addr == OFF_KEY |=> REG_RDATA == BYTE_ZERO)
    else $error("key port read not zero");
  pwrt_block_a: assert property (s_go_start |-> $past(pwrt_done_q))
    else $error("write started during power-up timer");
  erase_clear_a: assert property (s_go_end ##0 $past(ferase_q) |-> !ctrl_q.row_erase)
    else $error("row erase bit not cleared");

endmodule // dee_ctrl

// File: dee_ctrl_tb.sv
`timescale 1ns/1ps
module dee_ctrl_tb;
  import dee_pkg::*;
  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  localparam int WCYC = 8;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic POR_B = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata;
  logic busy;
  logic done_flag;
  logic op_done;
  logic row_erase;
  int err_count = 0;
  int tests_run = 0;
  int op_cnt = 0;

  dee_ctrl #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(12)) dut (
    .MCLK(MCLK), .RST_B(RST_B), .POR_B(POR_B), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .WRITE_BUSY(busy),
    .WRITE_DONE_FLAG(done_flag), .FLASH_OP_DONE(op_done), .FLASH_ROW_ERASE(row_erase));

  initial begin
    forever #5 MCLK = ~MCLK;
  end

  // the completion pulse is one cycle long, so count it on every edge
  always @(posedge MCLK) begin
    if (op_done === 1'b1) op_cnt <= op_cnt + 1;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge MCLK);
    reg_wr <= 1'b0;
    @(posedge MCLK);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge MCLK);
    reg_rd <= 1'b0;
    #1 v = rdata;
    chk(v & m, e);
    @(posedge MCLK);
  endtask

  task automatic go(input logic [7:0] c);
    wr(OFF_KEY, KEY_FIRST);
    wr(OFF_KEY, KEY_SECOND);
    wr(OFF_CTRL, c);
  endtask

  // entered one step after an edge; returns on an edge
  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1) begin
      @(posedge MCLK);
      #1;
      n++;
      if (n > 50) begin
        err_count++;
        end_of_test();
      end
    end
    @(posedge MCLK);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_power;
    rchk(OFF_CTRL, 8'hFF, 8'h00);
    wr(OFF_CTRL, 8'h04);
    go(8'h06);
    #1 chk({7'h00, busy}, 8'h00);
    @(posedge MCLK);
    rchk(OFF_CTRL, 8'hF7, 8'h04);
    rchk(OFF_KEY, 8'hFF, 8'h00);
    wr(OFF_ADR_HI, 8'hFF);
    rchk(OFF_ADR_HI, 8'hFF, 8'h03);
    $display("test power-up done");
  endtask

  task automatic t_array;
    int n;
    wr(OFF_ADR_LO, 8'hFF);
    wr(OFF_ADR_HI, 8'h03);
    wr(OFF_DATA, 8'hA5);
    wr(OFF_CTRL, 8'h04);
    go(8'h06);
    rchk(OFF_CTRL, 8'h0E, 8'h0E);
    // registers are frozen while the write runs
    wr(OFF_DATA, 8'h00);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_ADR_LO, 8'h00);
    #1 wait_idle(n);
    rchk(OFF_CTRL, 8'h0E, 8'h04);
    rchk(OFF_FLAG, 8'h10, 8'h10);
    chk({7'h00, done_flag}, 8'h01);
    wr(OFF_FLAG, 8'h00);
    rchk(OFF_FLAG, 8'h10, 8'h00);
    wr(OFF_DATA, 8'h11);
    rchk(OFF_DATA, 8'hFF, 8'h11);
    wr(OFF_CTRL, 8'h01);
    rchk(OFF_DATA, 8'hFF, 8'hA5);
    rchk(OFF_CTRL, 8'h01, 8'h00);
    $display("test array write done");
  endtask

  task automatic t_refuse;
    wr(OFF_CTRL, 8'h04);
    wr(OFF_KEY, KEY_FIRST);
    wr(OFF_ADR_LO, 8'hFF);
    wr(OFF_KEY, KEY_SECOND);
    wr(OFF_CTRL, 8'h06);
    #1 chk({7'h00, busy}, 8'h00);
    @(posedge MCLK);
    rchk(OFF_CTRL, 8'h0E, 8'h0C);
    wr(OFF_CTRL, 8'h00);
    go(8'h06);
    #1 chk({7'h00, busy}, 8'h00);
    @(posedge MCLK);
    rchk(OFF_CTRL, 8'h0A, 8'h08);
    $display("test refusals done");
  endtask

  task automatic t_select;
    wr(OFF_DATA, 8'h3C);
    wr(OFF_CTRL, 8'h81);
    rchk(OFF_DATA, 8'hFF, 8'h3C);
    wr(OFF_CTRL, 8'h41);
    rchk(OFF_DATA, 8'hFF, 8'h3C);
    rchk(OFF_CTRL, 8'hC1, 8'h40);
    wr(OFF_CTRL, 8'h84);
    wr(OFF_CTRL, 8'h86);
    rchk(OFF_CTRL, 8'hCA, 8'h88);
    $display("test select bits done");
  endtask

  task automatic t_flash;
    logic [7:0] modes [2] = '{8'h94, 8'h44};
    logic [7:0] c;
    int n;
    int start;
    for (int i = 0; i < 2; i++) begin
      c = modes[i];
      wr(OFF_CTRL, c);
      start = op_cnt;
      go(c | 8'h02);
      #1 chk({7'h00, row_erase}, {7'h00, c[7] & c[4]});
      wait_idle(n);
      chk(n[7:0], WCYC[7:0]);
      rchk(OFF_CTRL, 8'hDA, c & 8'hC0);
      chk(op_cnt[7:0] - start[7:0], 8'h01);
    end
    wr(OFF_CTRL, 8'h01);
    rchk(OFF_DATA, 8'hFF, 8'hA5);
    $display("test flash spaces done");
  endtask

  task automatic t_midreset;
    wr(OFF_CTRL, 8'h04);
    go(8'h06);
    RST_B <= 1'b0;
    repeat (3) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (14) @(posedge MCLK);
    #1 chk({7'h00, busy}, 8'h00);
    @(posedge MCLK);
    rchk(OFF_CTRL, 8'hFF, 8'h08);
    $display("test reset mid-write done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    POR_B <= 1'b1;
    t_power();
    t_array();
    t_refuse();
    t_select();
    t_flash();
    t_midreset();
    end_of_test();
  end
endmodule // dee_ctrl_tb
